/* File: shared/hmf_pkg.sv */
// Shared constants and types for the host message framer.
// Assumes a single 100 MHz clock and an asynchronous serial byte link.
package hmf_pkg;
	// Framing characters
	localparam logic [7:0] HMF_BEGIN_CHAR = 8'h7F;
	localparam logic [7:0] HMF_ESC_CHAR = 8'h7D;
	localparam logic [7:0] HMF_END_CHAR = 8'hFF;
	localparam logic [7:0] HMF_ESC_MASK = 8'h20;
	// Service code fields
	localparam int HMF_TYPE_HI = 15;
	localparam int HMF_TYPE_LO = 14;
	localparam int HMF_ID_W = 14;
	localparam logic [1:0] HMF_TYPE_REQUEST = 2'h0;
	localparam logic [1:0] HMF_TYPE_INDICATE = 2'h1;
	localparam logic [1:0] HMF_TYPE_CONFIRM = 2'h2;
	localparam logic [1:0] HMF_TYPE_UNUSED = 2'h3;
	localparam logic [13:0] HMF_ID_TRANSMIT = 14'h0041;
	localparam logic [13:0] HMF_ID_FLUSH = 14'h0042;
	localparam logic [13:0] HMF_ID_RECEIVE = 14'h0043;
	localparam logic [13:0] HMF_ID_LOCAL_MGMT = 14'h0044;
	localparam logic [13:0] HMF_ID_EXT_TRANSMIT = 14'h0045;
	localparam logic [13:0] HMF_ID_EXT_FLUSH = 14'h0046;
	localparam logic [13:0] HMF_ID_EXT_RECEIVE = 14'h0047;
	// Link timing: 1 Mbit/s at a 10 ns clock
	localparam int HMF_CLK_NS = 10;
	localparam int HMF_BIT_NS = 1000;
	localparam int HMF_BIT_CYCLES = HMF_BIT_NS / HMF_CLK_NS;
	// Serial receiver states
	typedef enum logic [3:0] {
		HMF_SR_IDLE = 4'b0001,
		HMF_SR_START = 4'b0010,
		HMF_SR_DATA = 4'b0100,
		HMF_SR_STOP = 4'b1000
	} hmf_srx_type;
	// Deframer states
	typedef enum logic [3:0] {
		HMF_R_HUNT = 4'b0001,
		HMF_R_LO = 4'b0010,
		HMF_R_HI = 4'b0100,
		HMF_R_PAY = 4'b1000
	} hmf_rx_type;
	// Framer states
	typedef enum logic [5:0] {
		HMF_T_IDLE = 6'b000001,
		HMF_T_BEGIN = 6'b000010,
		HMF_T_LO = 6'b000100,
		HMF_T_HI = 6'b001000,
		HMF_T_PAY = 6'b010000,
		HMF_T_END = 6'b100000
	} hmf_tx_type;
endpackage

/* File: shared/hmf_uart_if.sv */
// Byte handshake between the framer core and its serial engine.
// Assumes both ends share one clock.
interface hmf_uart_if;
	logic tx_valid;
	logic [7:0] tx_data;
	logic tx_ready;
	logic rx_valid;
	logic [7:0] rx_data;
	modport uart (input tx_valid, input tx_data, output tx_ready, output rx_valid, output rx_data);
	modport core (output tx_valid, output tx_data, input tx_ready, input rx_valid, input rx_data);
endinterface

/* File: rtl/hmf_uart.sv */
// 8N1 serial engine: one byte in, one byte out, LSB first.
// Assumes the serial input pin is asynchronous to mclk_i.
module hmf_uart #(
	parameter int BIT_CYCLES = hmf_pkg::HMF_BIT_CYCLES
) (
	input wire logic mclk_i,
	input wire logic nrst_i,
	hmf_uart_if.uart u,
	input wire logic host_txd_i,
	output logic host_rxd_o
);
	import hmf_pkg::*;

	localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
	localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2 - 1);

	////////////////////////////////////////////////////////////////////////
	// Receive
	logic sync1_r, sync2_r;
	hmf_srx_type srx_r;
	logic [15:0] rcnt_r;
	logic [2:0] rbit_r;
	logic [7:0] rsh_r;
	logic rvalid_r;
	logic [7:0] rdata_r;
	wire rtick_w = (rcnt_r == 16'h0000);

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
		end else begin
			sync1_r <= host_txd_i;
			sync2_r <= sync1_r;
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			srx_r <= HMF_SR_IDLE;
			rcnt_r <= 16'h0000;
			rbit_r <= 3'h0;
			rsh_r <= 8'h00;
			rvalid_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			rvalid_r <= 1'b0;
			if (!rtick_w)
				rcnt_r <= rcnt_r - 16'h0001;
			case (srx_r)
				HMF_SR_IDLE: if (!sync2_r) begin
					srx_r <= HMF_SR_START;
					rcnt_r <= HALF_LAST;
				end
				HMF_SR_START: if (rtick_w) begin
					srx_r <= sync2_r ? HMF_SR_IDLE : HMF_SR_DATA;
					rcnt_r <= BIT_LAST;
					rbit_r <= 3'h0;
				end
				HMF_SR_DATA: if (rtick_w) begin
					rsh_r <= {sync2_r, rsh_r[7:1]};
					rcnt_r <= BIT_LAST;
					rbit_r <= rbit_r + 3'h1;
					if (rbit_r == 3'h7)
						srx_r <= HMF_SR_STOP;
				end
				HMF_SR_STOP: if (rtick_w) begin
					// A missing stop bit drops the byte
					rvalid_r <= sync2_r;
					rdata_r <= rsh_r;
					srx_r <= HMF_SR_IDLE;
				end
				default: srx_r <= HMF_SR_IDLE;
			endcase
		end
	end
	assign u.rx_valid = rvalid_r;
	assign u.rx_data = rdata_r;

	////////////////////////////////////////////////////////////////////////
	// Transmit
	logic busy_r;
	logic [15:0] tcnt_r;
	logic [3:0] tbits_r;
	logic [8:0] tsh_r;
	logic rxd_r;

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			busy_r <= 1'b0;
			tcnt_r <= 16'h0000;
			tbits_r <= 4'h0;
			tsh_r <= 9'h1FF;
			rxd_r <= 1'b1;
		end else if (!busy_r) begin
			if (u.tx_valid) begin
				busy_r <= 1'b1;
				rxd_r <= 1'b0;
				tsh_r <= {1'b1, u.tx_data};
				tbits_r <= 4'h9;
				tcnt_r <= BIT_LAST;
			end
		end else if (tcnt_r != 16'h0000) begin
			tcnt_r <= tcnt_r - 16'h0001;
		end else if (tbits_r == 4'h0) begin
			busy_r <= 1'b0;
		end else begin
			rxd_r <= tsh_r[0];
			tsh_r <= {1'b1, tsh_r[8:1]};
			tbits_r <= tbits_r - 4'h1;
			tcnt_r <= BIT_LAST;
		end
	end
	assign u.tx_ready = !busy_r;
	assign host_rxd_o = rxd_r;
endmodule

/* File: rtl/hmf_framer.sv */
// Byte-stuffed message framer and deframer for the host serial link.
// Assumes the host honours the grant line and drives 8N1 at 1 Mbit/s.
module hmf_framer #(
	parameter logic [7:0] START_CHAR = hmf_pkg::HMF_BEGIN_CHAR,
	parameter int BIT_CYCLES = hmf_pkg::HMF_BIT_CYCLES
) (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic host_txd_i,
	output logic host_rxd_o,
	input wire logic host_to_module_send_request_i,
	output logic module_to_host_send_grant_o,
	input wire logic rx_accept_i,
	output logic rx_code_valid_o,
	output logic [15:0] rx_code_o,
	output logic rx_data_valid_o,
	output logic [7:0] rx_data_o,
	output logic rx_end_o,
	output logic rx_abort_o,
	input wire logic tx_start_i,
	input wire logic [15:0] tx_code_i,
	input wire logic tx_has_payload_i,
	output logic tx_busy_o,
	output logic tx_refused_o,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_last_i,
	output logic tx_ready_o,
	output logic req_outstanding_o,
	output logic [hmf_pkg::HMF_ID_W-1:0] req_id_o,
	output logic confirm_owed_o,
	output logic [hmf_pkg::HMF_ID_W-1:0] confirm_id_o
);
	import hmf_pkg::*;

	function automatic logic is_special(input logic [7:0] b);
		return (b == START_CHAR) || (b == HMF_BEGIN_CHAR) || (b == HMF_ESC_CHAR) || (b == HMF_END_CHAR);
	endfunction

	hmf_uart_if u ();

	hmf_uart #(.BIT_CYCLES(BIT_CYCLES)) serial_u (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.u(u),
		.host_txd_i(host_txd_i),
		.host_rxd_o(host_rxd_o)
	);

	////////////////////////////////////////////////////////////////////////
	// Flow control lines
	logic rts1_r, rts2_r;
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rts1_r <= 1'b0;
			rts2_r <= 1'b0;
			module_to_host_send_grant_o <= 1'b0;
		end else begin
			rts1_r <= host_to_module_send_request_i;
			rts2_r <= rts1_r;
			module_to_host_send_grant_o <= rx_accept_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Deframer
	hmf_rx_type rx_st;
	logic rx_esc_r;
	logic [7:0] rx_lo_r;
	wire [7:0] rx_b_w = u.rx_data;
	wire rx_is_start_w = (rx_b_w == START_CHAR);
	wire rx_is_end_w = (rx_b_w == HMF_END_CHAR);
	wire rx_is_esc_w = (rx_b_w == HMF_ESC_CHAR);
	wire [7:0] rx_val_w = rx_esc_r ? (rx_b_w | HMF_ESC_MASK) : rx_b_w;
	wire [15:0] rx_code_w = {rx_val_w, rx_lo_r};
	wire [1:0] rx_type_w = rx_code_w[HMF_TYPE_HI:HMF_TYPE_LO];
	wire [HMF_ID_W-1:0] rx_id_w = rx_code_w[HMF_ID_W-1:0];
	wire rx_data_w = u.rx_valid && !rx_is_start_w && !rx_is_end_w && !rx_is_esc_w;
	wire rx_code_done_w = rx_data_w && (rx_st == HMF_R_HI);

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_st <= HMF_R_HUNT;
			rx_esc_r <= 1'b0;
			rx_lo_r <= 8'h00;
			rx_code_valid_o <= 1'b0;
			rx_code_o <= 16'h0000;
			rx_data_valid_o <= 1'b0;
			rx_data_o <= 8'h00;
			rx_end_o <= 1'b0;
			rx_abort_o <= 1'b0;
		end else begin
			rx_code_valid_o <= 1'b0;
			rx_data_valid_o <= 1'b0;
			rx_end_o <= 1'b0;
			rx_abort_o <= 1'b0;
			if (u.rx_valid) begin
				if (rx_is_start_w) begin
					rx_st <= HMF_R_LO;
					rx_esc_r <= 1'b0;
					rx_abort_o <= (rx_st != HMF_R_HUNT);
				end else if (rx_st == HMF_R_HUNT) begin
					rx_esc_r <= 1'b0;
				end else if (rx_is_end_w) begin
					rx_end_o <= (rx_st == HMF_R_PAY);
					rx_abort_o <= (rx_st != HMF_R_PAY);
					rx_st <= HMF_R_HUNT;
					rx_esc_r <= 1'b0;
				end else if (rx_is_esc_w) begin
					rx_esc_r <= 1'b1;
				end else begin
					rx_esc_r <= 1'b0;
					case (rx_st)
						HMF_R_LO: begin
							rx_lo_r <= rx_val_w;
							rx_st <= HMF_R_HI;
						end
						HMF_R_HI: begin
							rx_code_o <= rx_code_w;
							rx_code_valid_o <= 1'b1;
							rx_st <= HMF_R_PAY;
						end
						HMF_R_PAY: begin
							rx_data_o <= rx_val_w;
							rx_data_valid_o <= 1'b1;
						end
						default: rx_st <= HMF_R_HUNT;
					endcase
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Framer
	hmf_tx_type tx_st;
	logic [15:0] tx_code_r;
	logic tx_pay_r;
	logic [7:0] tx_byte_r;
	logic tx_have_r;
	logic tx_last_r;
	logic tx_esc_sent_r;
	logic tx_valid_r;
	logic [7:0] tx_out_r;
	wire tx_is_req_w = (tx_code_i[HMF_TYPE_HI:HMF_TYPE_LO] == HMF_TYPE_REQUEST);
	wire tx_is_cfm_w = (tx_code_i[HMF_TYPE_HI:HMF_TYPE_LO] == HMF_TYPE_CONFIRM);
	wire tx_accept_w = tx_start_i && (tx_st == HMF_T_IDLE) && !(tx_is_req_w && req_outstanding_o);
	wire tx_take_w = tx_valid_i && tx_ready_o;
	wire tx_framing_w = (tx_st == HMF_T_BEGIN) || (tx_st == HMF_T_END);
	wire [7:0] tx_cur_w = (tx_st == HMF_T_BEGIN) ? START_CHAR :
		(tx_st == HMF_T_END) ? HMF_END_CHAR :
		(tx_st == HMF_T_LO) ? tx_code_r[7:0] :
		(tx_st == HMF_T_HI) ? tx_code_r[15:8] : tx_byte_r;
	wire tx_need_esc_w = !tx_framing_w && is_special(tx_cur_w);
	wire tx_fire_w = u.tx_ready && !tx_valid_r && rts2_r && (tx_st != HMF_T_IDLE) &&
		((tx_st != HMF_T_PAY) || tx_have_r);
	wire tx_adv_w = tx_fire_w && !(tx_need_esc_w && !tx_esc_sent_r);

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_st <= HMF_T_IDLE;
			tx_code_r <= 16'h0000;
			tx_pay_r <= 1'b0;
			tx_byte_r <= 8'h00;
			tx_have_r <= 1'b0;
			tx_last_r <= 1'b0;
			tx_esc_sent_r <= 1'b0;
			tx_valid_r <= 1'b0;
			tx_out_r <= 8'h00;
			tx_ready_o <= 1'b0;
			tx_busy_o <= 1'b0;
			tx_refused_o <= 1'b0;
		end else begin
			tx_valid_r <= tx_fire_w;
			tx_refused_o <= tx_start_i && (tx_st == HMF_T_IDLE) && !tx_accept_w;
			tx_busy_o <= (tx_st != HMF_T_IDLE) || tx_accept_w;
			tx_ready_o <= (tx_st == HMF_T_PAY) && !tx_have_r && !tx_take_w;
			if (tx_take_w) begin
				tx_byte_r <= tx_data_i;
				tx_last_r <= tx_last_i;
				tx_have_r <= 1'b1;
			end
			if (tx_accept_w) begin
				tx_code_r <= tx_code_i;
				tx_pay_r <= tx_has_payload_i;
				tx_st <= HMF_T_BEGIN;
			end
			if (tx_fire_w) begin
				if (!tx_adv_w) begin
					tx_out_r <= HMF_ESC_CHAR;
					tx_esc_sent_r <= 1'b1;
				end else begin
					tx_out_r <= tx_esc_sent_r ? (tx_cur_w & ~HMF_ESC_MASK) : tx_cur_w;
					tx_esc_sent_r <= 1'b0;
					case (tx_st)
						HMF_T_BEGIN: tx_st <= HMF_T_LO;
						HMF_T_LO: tx_st <= HMF_T_HI;
						HMF_T_HI: tx_st <= tx_pay_r ? HMF_T_PAY : HMF_T_END;
						HMF_T_PAY: begin
							tx_have_r <= 1'b0;
							if (tx_last_r)
								tx_st <= HMF_T_END;
						end
						HMF_T_END: tx_st <= HMF_T_IDLE;
						default: tx_st <= HMF_T_IDLE;
					endcase
				end
			end
		end
	end
	assign u.tx_valid = tx_valid_r;
	assign u.tx_data = tx_out_r;

	////////////////////////////////////////////////////////////////////////
	// Request and confirm bookkeeping; a set wins over a same-cycle clear
	wire req_set_w = tx_accept_w && tx_is_req_w;
	wire req_clr_w = rx_code_done_w && (rx_type_w == HMF_TYPE_CONFIRM) && (rx_id_w == req_id_o);
	wire cfm_set_w = rx_code_done_w && (rx_type_w == HMF_TYPE_REQUEST);
	wire cfm_clr_w = tx_accept_w && tx_is_cfm_w && (tx_code_i[HMF_ID_W-1:0] == confirm_id_o);

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			req_outstanding_o <= 1'b0;
			req_id_o <= '0;
			confirm_owed_o <= 1'b0;
			confirm_id_o <= '0;
		end else begin
			if (req_set_w) begin
				req_outstanding_o <= 1'b1;
				req_id_o <= tx_code_i[HMF_ID_W-1:0];
			end else if (req_clr_w)
				req_outstanding_o <= 1'b0;
			if (cfm_set_w) begin
				confirm_owed_o <= 1'b1;
				confirm_id_o <= rx_id_w;
			end else if (cfm_clr_w)
				confirm_owed_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	a_tx_grant_held: assert property (u.tx_valid |-> $past(rts2_r))
		else $error("byte sent without host grant");
	a_tx_begin_first: assert property (u.tx_valid && $past(tx_st == HMF_T_BEGIN) |-> u.tx_data == START_CHAR)
		else $error("frame did not open with start");
	a_tx_end_last: assert property (u.tx_valid && $past(tx_st == HMF_T_END) |-> u.tx_data == HMF_END_CHAR)
		else $error("frame did not close with end");
	a_tx_no_raw: assert property (u.tx_valid && $past(!tx_framing_w) |-> !is_special(u.tx_data) || u.tx_data == HMF_ESC_CHAR)
		else $error("framing byte in payload");
	a_tx_esc_pair: assert property (u.tx_valid && $past(!tx_framing_w) && u.tx_data == HMF_ESC_CHAR |=> tx_esc_sent_r)
		else $error("escape not followed by stuffed byte");
	a_rx_start_resync: assert property (u.rx_valid && rx_is_start_w |=> rx_st == HMF_R_LO && !rx_esc_r)
		else $error("start did not restart deframer");
	a_rx_unescape: assert property (rx_data_w && rx_esc_r && rx_st == HMF_R_PAY |=> rx_data_valid_o && rx_data_o[5])
		else $error("escaped byte not restored");
	a_rx_short_drop: assert property (u.rx_valid && rx_is_end_w && rx_st != HMF_R_PAY |=> !rx_end_o)
		else $error("short or stray message delivered");
	a_tx_one_request: assert property (tx_start_i && tx_st == HMF_T_IDLE && tx_is_req_w && req_outstanding_o
		|=> tx_refused_o && tx_st == HMF_T_IDLE)
		else $error("second request not refused");
endmodule

/* File: test/hmf_host_model.sv */
// Host side model: 8N1 serial sender and receiver with the flow lines.
// Assumes the framer's clock; one bit lasts BIT clock cycles.
module hmf_host_model #(
	parameter int BIT = 16
) (
	input wire logic clk_i,
	input wire logic rxd_i,
	input wire logic grant_i,
	output logic txd_o,
	output logic permit_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx_q[$];
	logic [7:0] sh;
	initial begin
		txd_o = 1'h1;
		permit_o = 1'h1;
	end
	////////////////////////////////////////////////////////////////
	task automatic set_permit(input logic v);
		@(negedge clk_i);
		permit_o = v;
	endtask
	// Waits for the grant first, so no byte starts while it is withheld
	task automatic send_byte(input logic [7:0] b);
		while (grant_i !== 1'h1) @(negedge clk_i);
		@(negedge clk_i);
		txd_o = 1'h0;
		repeat (BIT) @(negedge clk_i);
		for (int i = 0; i < 8; i++) begin
			txd_o = b[i];
			repeat (BIT) @(negedge clk_i);
		end
		txd_o = 1'h1;
		repeat (BIT) @(negedge clk_i);
	endtask
	////////////////////////////////////////////////////////////////
	// Mid-bit sampling; a bad stop bit drops the byte
	always begin
		@(negedge rxd_i);
		repeat (BIT / 2) @(negedge clk_i);
		for (int k = 0; k < 8; k++) begin
			repeat (BIT) @(negedge clk_i);
			sh[k] = rxd_i;
		end
		repeat (BIT) @(negedge clk_i);
		if (rxd_i === 1'h1) rx_q.push_back(sh);
	end
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the host message framer.
// Assumes host model and framer share mclk_i; bit time is shortened.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import hmf_pkg::*;
	localparam int BIT = 16;
	logic mclk_i = 1'h0;
	logic nrst_i = 1'h0;
	logic rx_accept_i = 1'h1;
	logic tx_start_i = 1'h0;
	logic tx_has_i = 1'h0;
	logic tx_valid_i = 1'h0;
	logic tx_last_i = 1'h0;
	logic [15:0] tx_code_i = 16'h0000;
	logic [7:0] tx_data_i = 8'h00;
	logic txd, rxd, permit, grant, rcv, rdv, rend, rab, busy, refd, rdy, req_o, owed;
	logic [15:0] rcode, got_code;
	logic [7:0] rdata;
	logic [13:0] req_id, conf_id;
	logic [7:0] rq[$];
	logic [7:0] exp_q[$];
	logic rend2;
	logic [15:0] rcode2;
	int n_end2 = 0;
	int err_count = 0;
	int num_checks = 0;
	int n_end = 0;
	int n_ab = 0;
	int n_ref = 0;
	logic [15:0] row_code [7] = '{16'h4041, 16'h8042, 16'hC043, 16'h4044, 16'h8045, 16'h4046, 16'hC047};
	logic [7:0] row_data [7] = '{8'h7F, 8'h7D, 8'hFF, 8'h5D, 8'h5F, 8'h00, 8'hA5};
	always #5 mclk_i = ~mclk_i;
	hmf_framer #(.BIT_CYCLES(BIT)) DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .host_txd_i(txd), .host_rxd_o(rxd),
		.host_to_module_send_request_i(permit), .module_to_host_send_grant_o(grant), .rx_accept_i(rx_accept_i),
		.rx_code_valid_o(rcv), .rx_code_o(rcode), .rx_data_valid_o(rdv), .rx_data_o(rdata), .rx_end_o(rend),
		.rx_abort_o(rab), .tx_start_i(tx_start_i), .tx_code_i(tx_code_i), .tx_has_payload_i(tx_has_i),
		.tx_busy_o(busy), .tx_refused_o(refd), .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i),
		.tx_last_i(tx_last_i), .tx_ready_o(rdy), .req_outstanding_o(req_o), .req_id_o(req_id),
		.confirm_owed_o(owed), .confirm_id_o(conf_id));
	// Second build with the alternative start value; it listens to the same host stream
	hmf_framer #(.START_CHAR(8'h7E), .BIT_CYCLES(BIT)) DUT_ALT (.mclk_i(mclk_i), .nrst_i(nrst_i),
		.host_txd_i(txd), .host_rxd_o(), .host_to_module_send_request_i(permit),
		.module_to_host_send_grant_o(), .rx_accept_i(rx_accept_i), .rx_code_valid_o(), .rx_code_o(rcode2),
		.rx_data_valid_o(), .rx_data_o(), .rx_end_o(rend2), .rx_abort_o(), .tx_start_i(tx_start_i),
		.tx_code_i(tx_code_i), .tx_has_payload_i(tx_has_i), .tx_busy_o(), .tx_refused_o(),
		.tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i), .tx_last_i(tx_last_i), .tx_ready_o(),
		.req_outstanding_o(), .req_id_o(), .confirm_owed_o(), .confirm_id_o());
	hmf_host_model #(.BIT(BIT)) u_host (.clk_i(mclk_i), .rxd_i(rxd), .grant_i(grant), .txd_o(txd),
		.permit_o(permit));
	////////////////////////////////////////////////////////////////
	// One-cycle pulses are caught here so no test misses them
	always @(negedge mclk_i) begin
		if (rcv === 1'h1) got_code = rcode;
		if (rdv === 1'h1) rq.push_back(rdata);
		if (rend === 1'h1) n_end++;
		if (rab === 1'h1) n_ab++;
		if (refd === 1'h1) n_ref++;
		if (rend2 === 1'h1) n_end2++;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic put(input logic [7:0] b);
		if (b == HMF_BEGIN_CHAR || b == HMF_ESC_CHAR || b == HMF_END_CHAR) begin
			exp_q.push_back(HMF_ESC_CHAR);
			exp_q.push_back(b & ~HMF_ESC_MASK);
		end else exp_q.push_back(b);
	endtask
	task automatic build(input logic [15:0] c, input logic [7:0] d, input logic has);
		exp_q = {};
		exp_q.push_back(HMF_BEGIN_CHAR);
		put(c[7:0]);
		put(c[15:8]);
		if (has) put(d);
		exp_q.push_back(HMF_END_CHAR);
	endtask
	task automatic mod_send(input logic [15:0] c, input logic [7:0] d, input logic has, input logic stall);
		u_host.rx_q = {};
		if (stall) u_host.set_permit(1'h0);
		repeat (4) @(negedge mclk_i);
		tx_code_i = c;
		tx_has_i = has;
		tx_start_i = 1'h1;
		@(negedge mclk_i);
		tx_start_i = 1'h0;
		if (stall) begin
			repeat (20 * BIT) @(negedge mclk_i);
			chk("stall busy", 1, busy);
			chk("stall bytes", 0, u_host.rx_q.size());
			chk("stall line", 1, rxd);
			u_host.set_permit(1'h1);
		end
		if (has) begin
			tx_valid_i = 1'h1;
			tx_data_i = d;
			tx_last_i = 1'h1;
			for (int n = 0; n < 4000 && rdy !== 1'h1; n++) @(negedge mclk_i);
			@(negedge mclk_i);
			tx_valid_i = 1'h0;
			chk("ready drops", 0, rdy);
		end
		repeat (2) @(negedge mclk_i);
		for (int n = 0; n < 20000 && busy !== 1'h0; n++) @(negedge mclk_i);
		repeat (12 * BIT) @(negedge mclk_i);
	endtask
	task automatic chk_stream();
		chk("frame length", exp_q.size(), u_host.rx_q.size());
		foreach (exp_q[i]) chk("frame byte", exp_q[i], u_host.rx_q[i]);
	endtask
	task automatic host_send();
		rq = {};
		foreach (exp_q[i]) u_host.send_byte(exp_q[i]);
		repeat (4) @(negedge mclk_i);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#500000;
		err_count++;
		$display("[FAIL] watchdog expected finish seen timeout");
		end_sim();
	end
	initial begin
		int e;
		int a;
		@(negedge mclk_i);
		chk("reset line", 1, rxd);
		chk("reset grant", 0, grant);
		chk("reset busy", 0, busy);
		chk("reset ready", 0, rdy);
		chk("reset trackers", 0, {req_o, owed});
		@(negedge mclk_i);
		nrst_i = 1'h1;
		repeat (2) @(negedge mclk_i);
		chk("grant on", 1, grant);
		rx_accept_i = 1'h0;
		repeat (2) @(negedge mclk_i);
		chk("grant off", 0, grant);
		rx_accept_i = 1'h1;
		$display("test reset done");
		for (int r = 0; r < 7; r++) begin
			build(row_code[r], row_data[r], 1'h1);
			mod_send(row_code[r], row_data[r], 1'h1, 1'h0);
			chk_stream();
			e = n_end;
			host_send();
			chk("rx code", row_code[r], got_code);
			chk("rx byte", row_data[r], rq[0]);
			chk("rx count", 1, rq.size());
			chk("rx end", e + 1, n_end);
			$display("test row %0d done", r);
		end
		chk("indicate untracked", 0, {req_o, owed});
		build(16'h0043, 8'h00, 1'h0);
		mod_send(16'h0043, 8'h00, 1'h0, 1'h1);
		chk_stream();
		chk("req pending", 1, req_o);
		chk("req id", 14'h0043, req_id);
		e = n_ref;
		mod_send(16'h0041, 8'h00, 1'h0, 1'h0);
		chk("refused", e + 1, n_ref);
		chk("refused bytes", 0, u_host.rx_q.size());
		build(16'h8042, 8'h00, 1'h0);
		host_send();
		chk("wrong id confirm", 1, req_o);
		build(16'h8043, 8'h00, 1'h0);
		host_send();
		chk("confirm clears", 0, req_o);
		$display("test request done");
		build(16'h0044, 8'h00, 1'h0);
		host_send();
		chk("owed set", 1, owed);
		chk("owed id", 14'h0044, conf_id);
		build(16'h8044, 8'h11, 1'h1);
		mod_send(16'h8044, 8'h11, 1'h1, 1'h0);
		chk_stream();
		chk("owed cleared", 0, owed);
		$display("test confirm done");
		e = n_end;
		a = n_ab;
		exp_q = {8'h7F, 8'h41, 8'h7F, 8'h46, 8'h40, 8'h22, 8'hFF};
		host_send();
		chk("restart abort", a + 1, n_ab);
		chk("restart code", 16'h4046, got_code);
		chk("restart byte", 8'h22, rq[0]);
		chk("restart end", e + 1, n_end);
		exp_q = {8'h7F, 8'h41, 8'hFF};
		host_send();
		chk("short abort", a + 2, n_ab);
		chk("short no end", e + 1, n_end);
		$display("test abort done");
		e = n_end2;
		exp_q = {8'h7E, 8'h41, 8'h40, 8'hFF};
		host_send();
		chk("alt code", 16'h4041, rcode2);
		chk("alt end", e + 1, n_end2);
		chk("main ignores alt", a + 2, n_ab);
		$display("test alt start done");
		end_sim();
	end
endmodule
